// file: logic/rsev_cfg.svh
// timing, register map and reset constants of the reset and vector block
`ifndef RSEV_CFG_SVH
`define RSEV_CFG_SVH
// clock rate and times in their own units, cycle counts derived
`define RSEV_CLK_KHZ     20000
`define RSEV_HALT_MS     4000
`define RSEV_HALT_CYC    (`RSEV_HALT_MS * `RSEV_CLK_KHZ)
`define RSEV_DEAD_MS     1000
`define RSEV_DEAD_CYC    (`RSEV_DEAD_MS * `RSEV_CLK_KHZ)
`define RSEV_HOLD_CYC    8'd16
// register byte offsets
`define RSEV_A_STATUS    8'h00
`define RSEV_A_RANDOM    8'h04
`define RSEV_A_WIRED     8'h08
`define RSEV_A_CONFIG    8'h0c
`define RSEV_A_CTRL      8'h10
`define RSEV_A_VECREQ    8'h14
`define RSEV_A_VECLO     8'h18
`define RSEV_A_VECHI     8'h1c
`define RSEV_A_CAUSE     8'h20
// status register fields and reset value
`define RSEV_ST_BEV      22
`define RSEV_ST_TS       21
`define RSEV_ST_SR       20
`define RSEV_ST_ERL      2
`define RSEV_ST_EXL      1
`define RSEV_STATUS_RST  32'h0040_0004
`define RSEV_CFG_RST     32'h0002_4000
`define RSEV_RAND_MAX    5'h1f
`define RSEV_WIRED_RST   5'h00
// control register fields
`define RSEV_C_DMEN      0
`define RSEV_C_DMCLR     1
`define RSEV_C_HALTCLR   2
`define RSEV_C_SHUT      3
`define RSEV_C_MODE64    4
// bus responses
`define RSEV_RESP_OK     2'h0
`define RSEV_RESP_ERR    2'h2
// vector bases and offsets, sign-extended form
`define RSEV_B_RESET     64'hffff_ffff_bfc0_0000
`define RSEV_B_UNCACHED  64'hffff_ffff_a000_0000
`define RSEV_B_BOOT      64'hffff_ffff_bfc0_0200
`define RSEV_B_NORMAL    64'hffff_ffff_8000_0000
`define RSEV_O_RESET     64'h0000
`define RSEV_O_CERR      64'h0100
`define RSEV_O_TLB       64'h0000
`define RSEV_O_EXTENDED_TRANSLATION_MISS      64'h0080
`define RSEV_O_OTHER     64'h0180
`endif

// file: logic/rsev_pkg.sv
// types shared by the reset and vector block
package rsev_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    rsev_run    = 2'b00,
    rsev_hold   = 2'b01,
    rsev_vector = 2'b10,
    rsev_off    = 2'b11
  } rsev_state_e;
  // exception classes for vector lookup
  typedef enum logic [2:0] {
    rsev_cls_reset = 3'b000,
    rsev_cls_cerr  = 3'b001,
    rsev_cls_tlb   = 3'b010,
    rsev_cls_extended_translation_miss  = 3'b011,
    rsev_cls_other = 3'b100
  } rsev_class_e;
  // cause of the last reset
  typedef enum logic [2:0] {
    rsev_cause_rtc      = 3'b000,
    rsev_cause_switch   = 3'b001,
    rsev_cause_deadman  = 3'b010,
    rsev_cause_shutdown = 3'b011,
    rsev_cause_halt     = 3'b100
  } rsev_cause_e;
endpackage : rsev_pkg

// file: logic/rsev_timeout.sv
// timeout counter used by the boot halt timer and the deadman watchdog
`timescale 1ns/1ps
`include "rsev_cfg.svh"
module rsev_timeout #(
  parameter int unsigned LIMIT = `RSEV_HALT_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_clear,
  input  wire logic i_run,
  output logic      o_expired
);
  import rsev_pkg::*;
  // 27 bits covers the four second count at 20 MHz
  typedef struct packed {
    logic [26:0] cnt;      // cycles elapsed
    logic        expired;  // one-cycle pulse at the limit
  } rsev_tmr_s;
  rsev_tmr_s s;
  rsev_tmr_s next_s;

  // count while running, clear wins over counting
  always_comb
  begin
    next_s         = s;
    next_s.expired = 1'b0;
    if (i_clear)
      next_s.cnt = '0;
    else if (i_run)
    begin
      if (s.cnt == 27'(LIMIT - 1))
      begin
        next_s.cnt     = '0;
        next_s.expired = 1'b1;
      end
      else
        next_s.cnt = s.cnt + 27'd1;
    end
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_expired = s.expired;
endmodule : rsev_timeout

// file: logic/rsev_vec_gen.sv
// exception vector lookup: base by class and bootstrap select plus offset
`timescale 1ns/1ps
`include "rsev_cfg.svh"
module rsev_vec_gen (
  input  wire rsev_pkg::rsev_class_e i_class,
  input  wire logic                  i_bev,
  input  wire logic                  i_exl,
  input  wire logic                  i_mode64,
  output logic [63:0]                o_vector
);
  import rsev_pkg::*;
  logic [63:0] base;  // selected base, sign-extended
  logic [63:0] off;   // class offset
  logic [63:0] sum;   // final 64-bit address

  // class decode; a translation miss under exl falls to the general vector
  always_comb
  begin
    unique case (i_class)
      rsev_cls_reset:
      begin
        base = `RSEV_B_RESET;
        off  = `RSEV_O_RESET;  // RQ1
      end
      rsev_cls_cerr:
      begin
        base = i_bev ? `RSEV_B_BOOT : `RSEV_B_UNCACHED;
        off  = `RSEV_O_CERR;  // RQ2
      end
      rsev_cls_tlb:
      begin
        base = i_bev ? `RSEV_B_BOOT : `RSEV_B_NORMAL;
        off  = i_exl ? `RSEV_O_OTHER : `RSEV_O_TLB;  // RQ3
      end
      rsev_cls_extended_translation_miss:
      begin
        base = i_bev ? `RSEV_B_BOOT : `RSEV_B_NORMAL;
        off  = i_exl ? `RSEV_O_OTHER : `RSEV_O_EXTENDED_TRANSLATION_MISS;  // RQ4
      end
      default:
      begin
        // codes 5..7 are not classes; treated as general exceptions
        base = i_bev ? `RSEV_B_BOOT : `RSEV_B_NORMAL;
        off  = `RSEV_O_OTHER;  // RQ4
      end
    endcase
    sum      = base + off;  // RQ18
    // 32-bit mode reports only the low word
    o_vector = i_mode64 ? sum : {32'h0, sum[31:0]};  // RQ5
  end
endmodule : rsev_vec_gen

// file: logic/rsev_top.sv
// reset source sequencer, core reset values and vector unit with axi4-lite
// What this block does
// RQ1: reset and nmi vector bfc00000, bootstrap forced
// RQ2: cache error offset 0x100, base by bootstrap
// RQ3: translation miss, exl zero, offset zero
// RQ4: extended miss 0x80, all others 0x180
// RQ5: 32-bit mode uses 32-bit bases
// RQ6: rtc pin reset fully initializes everything
// RQ7: pin and watchdog resets skip self-refresh
// RQ8: after reset take bus, fetch reset vector
// RQ9: switch reset spares rtc timer and power
// RQ10: watchdog not cleared in time resets device
// RQ11: shutdown: self-refresh, power off, then reset
// RQ12: halt timer uncleared four seconds resets device
// RQ13: reset clears translation shutdown, soft reset flags
// RQ14: reset sets error level and bootstrap select
// RQ15: random loads 31, wired loads zero
// RQ16: config reset value on defined bits
// RQ17: wired cleared on every reset
// RQ18: vector is base plus offset, sign-extended; 32-bit mode zero-fills the high word
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "rsev_cfg.svh"
module rsev_top #(
  parameter int unsigned HALT_CYC = `RSEV_HALT_CYC,
  parameter int unsigned DEAD_CYC = `RSEV_DEAD_CYC
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_rtc_domain_reset_pin,
  input  wire logic                 i_reset_switch_pin,
  input  wire logic                 i_awvalid,
  input  wire logic [7:0]           i_awaddr,
  input  wire logic                 i_wvalid,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  input  wire logic                 i_bready,
  input  wire logic                 i_arvalid,
  input  wire logic [7:0]           i_araddr,
  input  wire logic                 i_rready,
  output logic                      o_awready,
  output logic                      o_wready,
  output logic                      o_bvalid,
  output logic [1:0]                o_bresp,
  output logic                      o_arready,
  output logic                      o_rvalid,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_core_reset,
  output logic                      o_bus_master,
  output logic                      o_fetch_strobe,
  output logic [63:0]               o_fetch_vector,
  output logic                      o_main_power_output,
  output logic                      o_dram_self_refresh,
  output rsev_pkg::rsev_cause_e     o_reset_cause
);
  import rsev_pkg::*;

  // whole block state
  typedef struct packed {
    rsev_state_e st;       // sequencer state
    logic [7:0]  hold;     // cycles spent in reset hold
    logic [1:0]  rtc_sy;   // rtc pin synchroniser
    logic [1:0]  sw_sy;    // switch pin synchroniser
    logic [31:0] status;   // core status register
    logic [4:0]  random;   // replacement index
    logic [4:0]  wired;    // wired boundary
    logic [31:0] core_cfg; // core configuration
    logic        dm_en;    // watchdog enabled
    logic        dm_kick;  // watchdog clear pulse
    logic        halt_arm; // halt timer still waiting
    logic        mode64;   // 64-bit addressing
    logic [2:0]  vclass;   // requested exception class
    logic [63:0] vec;      // looked-up vector
    rsev_cause_e cause;    // last reset cause
    logic        core_rst; // core held in reset
    logic        bus_mst;  // bus mastership taken
    logic        fetch;    // reset fetch pulse
    logic        main_power_output;   // main power output
    logic        selfref;  // dram self-refresh request
    logic        awready;  // axi write address ready
    logic        wready;   // axi write data ready
    logic        aw_hold;  // address taken
    logic        w_hold;   // data taken
    logic [7:0]  waddr;    // latched write address
    logic [31:0] wdata;    // latched write data
    logic [3:0]  wstrb;    // latched byte lanes
    logic        bvalid;   // write answer
    logic [1:0]  bresp;    // write answer code
    logic        arready;  // axi read address ready
    logic        rvalid;   // read answer
    logic [31:0] rdata;    // read data
    logic [1:0]  rresp;    // read answer code
  } rsev_top_s;
  rsev_top_s s;
  rsev_top_s next_s;

  logic        halt_exp;  // halt timer ran out
  logic        dead_exp;  // watchdog ran out
  logic [63:0] vg_vec;    // lookup result
  logic        do_wr;     // both halves of a write are in
  logic        shut_req;  // shutdown command written

  // mapped, word-aligned offsets; shared by read and write decode
  function automatic logic rsev_mapped(input logic [7:0] a);
    rsev_mapped = (a[1:0] == 2'b00) && (a <= `RSEV_A_CAUSE);
  endfunction : rsev_mapped

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] rsev_merge(input logic [31:0] o,
                                             input logic [31:0] d,
                                             input logic [3:0]  b);
    rsev_merge = o;
    for (int i = 0; i < 4; i++)
      if (b[i])
        rsev_merge[8*i +: 8] = d[8*i +: 8];
  endfunction : rsev_merge

  // read decode; unmapped reads return zero
  function automatic logic [31:0] rsev_read(input logic [7:0] a,
                                            input rsev_top_s  t);
    unique case (a)
      `RSEV_A_STATUS: rsev_read = t.status;
      `RSEV_A_RANDOM: rsev_read = {27'h0, t.random};
      `RSEV_A_WIRED:  rsev_read = {27'h0, t.wired};
      `RSEV_A_CONFIG: rsev_read = t.core_cfg;
      `RSEV_A_CTRL:   rsev_read = {27'h0, t.mode64, 1'b0, t.halt_arm,
                                   1'b0, t.dm_en};
      `RSEV_A_VECREQ: rsev_read = {29'h0, t.vclass};
      `RSEV_A_VECLO:  rsev_read = t.vec[31:0];
      `RSEV_A_VECHI:  rsev_read = t.vec[63:32];
      `RSEV_A_CAUSE:  rsev_read = {29'h0, t.cause};
      default:        rsev_read = 32'h0;
    endcase
  endfunction : rsev_read

  // boot halt timer: starts when the rtc pin releases
  rsev_timeout #(.LIMIT(HALT_CYC)) u_halt (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_clear   (s.rtc_sy[1]),
    .i_run     (s.halt_arm),
    .o_expired (halt_exp)
  );

  // deadman watchdog: counts only while software keeps it enabled
  rsev_timeout #(.LIMIT(DEAD_CYC)) u_dead (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_clear   (s.dm_kick | ~s.dm_en),
    .i_run     (s.dm_en),
    .o_expired (dead_exp)
  );

  // vector lookup; the reset class is forced outside normal running
  rsev_vec_gen u_vec (
    .i_class  (s.st == rsev_run ? rsev_class_e'(s.vclass) : rsev_cls_reset),
    .i_bev    (s.status[`RSEV_ST_BEV]),
    .i_exl    (s.status[`RSEV_ST_EXL]),
    .i_mode64 (s.mode64),
    .o_vector (vg_vec)
  );

  assign do_wr = s.aw_hold & s.w_hold & ~s.bvalid;

  // next-state logic: bus slave, register writes, reset sequencer
  always_comb
  begin
    next_s         = s;
    shut_req       = 1'b0;
    next_s.rtc_sy  = {s.rtc_sy[0], i_rtc_domain_reset_pin};
    next_s.sw_sy   = {s.sw_sy[0], i_reset_switch_pin};
    next_s.dm_kick = 1'b0;
    next_s.vec     = vg_vec;                                    // RQ18
    // write channels: each half is taken on its own, in either order
    next_s.awready = i_awvalid & ~s.awready & ~s.aw_hold & ~s.bvalid;
    next_s.wready  = i_wvalid & ~s.wready & ~s.w_hold & ~s.bvalid;
    if (i_awvalid && s.awready)
    begin
      next_s.aw_hold = 1'b1;
      next_s.waddr   = i_awaddr;
    end
    if (i_wvalid && s.wready)
    begin
      next_s.w_hold = 1'b1;
      next_s.wdata  = i_wdata;
      next_s.wstrb  = i_wstrb;
    end
    if (s.bvalid && i_bready)
      next_s.bvalid = 1'b0;
    // the write lands once both halves are in
    if (do_wr)
    begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = rsev_mapped(s.waddr) ? `RSEV_RESP_OK : `RSEV_RESP_ERR;
      // core registers take writes only while running
      if (s.st == rsev_run)
      begin
        unique case (s.waddr)
          `RSEV_A_STATUS:
            next_s.status = rsev_merge(s.status, s.wdata, s.wstrb);
          `RSEV_A_WIRED:
            if (s.wstrb[0])
              next_s.wired = s.wdata[4:0];
          `RSEV_A_CONFIG:
            next_s.core_cfg = rsev_merge(s.core_cfg, s.wdata, s.wstrb);
          `RSEV_A_CTRL:
            if (s.wstrb[0])
            begin
              next_s.dm_en   = s.wdata[`RSEV_C_DMEN];
              next_s.dm_kick = s.wdata[`RSEV_C_DMCLR];
              next_s.mode64  = s.wdata[`RSEV_C_MODE64];
              if (s.wdata[`RSEV_C_HALTCLR])
                next_s.halt_arm = 1'b0;
              shut_req = s.wdata[`RSEV_C_SHUT];
            end
          `RSEV_A_VECREQ:
            if (s.wstrb[0])
            begin
              next_s.vclass = s.wdata[2:0];
              // an nmi request forces the bootstrap vectors
              if (s.wdata[2:0] == 3'(rsev_cls_reset))
                next_s.status[`RSEV_ST_BEV] = 1'b1;           // RQ1
            end
          default:
            next_s.vclass = s.vclass;  // read-only or unmapped
        endcase
      end
    end
    // read channel: one read in flight, answer the cycle after taking
    if (s.rvalid && i_rready)
      next_s.rvalid = 1'b0;
    next_s.arready = i_arvalid & ~s.arready & ~s.rvalid;
    if (i_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rsev_read(i_araddr, s);
      next_s.rresp  = rsev_mapped(i_araddr) ? `RSEV_RESP_OK : `RSEV_RESP_ERR;
    end
    // sequencer; the rtc pin outranks every other source
    unique case (s.st)
      rsev_hold:
      begin
        // core registers sit at their reset values while held
        next_s.status = `RSEV_STATUS_RST;                       // RQ13 RQ14
        next_s.random = `RSEV_RAND_MAX;                         // RQ15
        next_s.wired  = `RSEV_WIRED_RST;                        // RQ15 RQ17
        next_s.core_cfg = `RSEV_CFG_RST;                        // RQ16
        next_s.vclass = 3'(rsev_cls_reset);
        next_s.mode64 = 1'b0;
        next_s.hold   = s.hold + 8'd1;
        if (s.hold == `RSEV_HOLD_CYC - 8'd1)
        begin
          next_s.st    = rsev_vector;
          next_s.fetch = 1'b1;                                  // RQ8
        end
      end
      rsev_vector:
      begin
        // release the core onto the bus at the reset vector
        next_s.st       = rsev_run;
        next_s.fetch    = 1'b0;
        next_s.core_rst = 1'b0;
        next_s.bus_mst  = 1'b1;                                 // RQ8
      end
      rsev_run:
      begin
        // random walks down to the wired boundary and wraps
        if (s.random <= s.wired)
          next_s.random = `RSEV_RAND_MAX;
        else
          next_s.random = s.random - 5'd1;
      end
      rsev_off:
        next_s.st = rsev_off;  // powered down until a pin reset
    endcase
    // reset sources in priority order
    if (s.rtc_sy[1])
    begin
      next_s.st       = rsev_hold;                              // RQ6
      next_s.cause    = rsev_cause_rtc;
      next_s.halt_arm = 1'b1;
      next_s.main_power_output   = 1'b1;
      next_s.selfref  = 1'b0;                                   // RQ7
    end
    else if (s.sw_sy[1])
    begin
      // rtc timer and power state survive; power is back if it was off
      next_s.st      = rsev_hold;                               // RQ9
      next_s.cause   = rsev_cause_switch;
      next_s.main_power_output  = 1'b1;
      next_s.selfref = 1'b0;                                    // RQ7
    end
    else if (s.st != rsev_off && dead_exp)
    begin
      next_s.st      = rsev_hold;                               // RQ10
      next_s.cause   = rsev_cause_deadman;
      next_s.selfref = 1'b0;                                    // RQ7
    end
    else if (s.st != rsev_off && halt_exp)
    begin
      next_s.st       = rsev_hold;                              // RQ12
      next_s.cause    = rsev_cause_halt;
      next_s.halt_arm = 1'b0;
    end
    else if (shut_req)
    begin
      next_s.st      = rsev_off;                                // RQ11
      next_s.cause   = rsev_cause_shutdown;
      next_s.selfref = 1'b1;
      next_s.main_power_output  = 1'b0;
    end
    // any reset entry restarts the hold and drops the bus
    if (next_s.st inside {rsev_hold, rsev_off} && s.st != next_s.st)
    begin
      next_s.hold     = 8'h00;
      next_s.core_rst = 1'b1;
      next_s.bus_mst  = 1'b0;
      next_s.fetch    = 1'b0;
      next_s.dm_en    = 1'b0;
    end
    if (s.rtc_sy[1])
      next_s.hold = 8'h00;  // stay held while the pin is asserted
  end

  // state register; reset behaves like an rtc pin reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s          <= '0;
      s.st       <= rsev_hold;                                  // RQ6
      s.core_rst <= 1'b1;
      s.halt_arm <= 1'b1;
      s.main_power_output   <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign o_awready           = s.awready;
  assign o_wready            = s.wready;
  assign o_bvalid            = s.bvalid;
  assign o_bresp             = s.bresp;
  assign o_arready           = s.arready;
  assign o_rvalid            = s.rvalid;
  assign o_rdata             = s.rdata;
  assign o_rresp             = s.rresp;
  assign o_core_reset        = s.core_rst;
  assign o_bus_master        = s.bus_mst;
  assign o_fetch_strobe      = s.fetch;
  assign o_fetch_vector      = s.vec;
  assign o_main_power_output = s.main_power_output;
  assign o_dram_self_refresh = s.selfref;
  assign o_reset_cause       = s.cause;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  reset_vector_a: assert property ( // RQ1 RQ5
    o_fetch_strobe |-> o_fetch_vector == 64'h0000_0000_bfc0_0000
                       && s.status[`RSEV_ST_BEV])
    else $error("reset fetch vector wrong");
  cerr_vector_a: assert property ( // RQ2
    s.st == rsev_run && $past(s.st) == rsev_run
    && $past(s.vclass) == 3'b001 && $past(s.status[`RSEV_ST_BEV])
    && $past(s.mode64) |-> s.vec == 64'hffff_ffff_bfc0_0300)
    else $error("cache error vector wrong");
  tlb_vector_a: assert property ( // RQ3 RQ18
    s.st == rsev_run && $past(s.st) == rsev_run
    && $past(s.vclass) == 3'b010 && !$past(s.status[`RSEV_ST_BEV])
    && !$past(s.status[`RSEV_ST_EXL]) && $past(s.mode64)
    |-> s.vec == 64'hffff_ffff_8000_0000)
    else $error("tlb miss vector wrong");
  extended_translation_miss_vector_a: assert property ( // RQ4 RQ5
    s.st == rsev_run && $past(s.st) == rsev_run
    && $past(s.vclass) == 3'b011 && !$past(s.status[`RSEV_ST_BEV])
    && !$past(s.status[`RSEV_ST_EXL]) && !$past(s.mode64)
    |-> s.vec == 64'h0000_0000_8000_0080)
    else $error("extended miss vector wrong");
  rtc_reset_a: assert property ( // RQ6 RQ7
    s.rtc_sy[1] |=> s.st == rsev_hold && o_core_reset
                    && o_reset_cause == rsev_cause_rtc && !o_dram_self_refresh)
    else $error("rtc pin reset not taken");
  switch_power_a: assert property ( // RQ9
    s.sw_sy[1] && !s.rtc_sy[1] && s.st != rsev_off
    |=> o_main_power_output && o_reset_cause == rsev_cause_switch)
    else $error("switch reset wrong");
  release_seq_a: assert property ( // RQ8
    $rose(o_fetch_strobe) |=> o_bus_master && !o_core_reset && !o_fetch_strobe)
    else $error("reset release sequence wrong");
  deadman_a: assert property ( // RQ10
    dead_exp && !s.rtc_sy[1] && !s.sw_sy[1] && s.st != rsev_off
    |=> s.st == rsev_hold && o_reset_cause == rsev_cause_deadman)
    else $error("watchdog reset missing");
  shutdown_a: assert property ( // RQ11
    shut_req && !s.rtc_sy[1] && !s.sw_sy[1] && !dead_exp && !halt_exp
    |=> o_dram_self_refresh && !o_main_power_output && o_core_reset)
    else $error("shutdown sequence wrong");
  halt_reset_a: assert property ( // RQ12
    halt_exp && !s.rtc_sy[1] && !s.sw_sy[1] && !dead_exp
    && s.st != rsev_off |=> s.st == rsev_hold && !s.halt_arm)
    else $error("halt timer reset missing");
  core_values_a: assert property ( // RQ13 RQ14 RQ15 RQ16 RQ17
    $fell(o_core_reset) |-> s.status == `RSEV_STATUS_RST
    && s.wired == 5'h00 && s.random == 5'h1f && s.core_cfg == 32'h0002_4000)
    else $error("core reset values wrong");

  rtc_seen_c:   cover property (s.rtc_sy[1] ##1 s.st == rsev_hold);
  dead_seen_c:  cover property (o_reset_cause == rsev_cause_deadman
                                && o_fetch_strobe);
  shut_seen_c:  cover property (s.st == rsev_off);
  fetch_seen_c: cover property ($rose(o_bus_master));
endmodule : rsev_top

// file: verif/rsev_power_model.sv
// supply and reset switch circuitry facing the reset block
`timescale 1ns/1ps
module rsev_power_model (
  input  wire logic i_clk,
  input  wire logic i_press,
  output logic      o_rtc_domain_reset_pin,
  output logic      o_reset_switch_pin
);
  // rtc pin held while power comes up, then let go
  initial
  begin
    o_rtc_domain_reset_pin = 1'b1;
    repeat (10) @(posedge i_clk);
    o_rtc_domain_reset_pin <= 1'b0;
  end
  // switch is a plain level, no debounce modelled
  always @(posedge i_clk)
    o_reset_switch_pin <= i_press;
endmodule : rsev_power_model

// file: verif/reset_sources_and_exception_vectors_test.sv
// self-checking bench of the reset sources and vector block
`timescale 1ns/1ps
module reset_sources_and_exception_vectors_test;
  import rsev_pkg::*;
  logic        i_clk, i_rst, press, rtc_pin, sw_pin, awvalid, wvalid;
  logic        bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb = 4'hf; // full words only
  wire         awready, wready, bvalid, arready, rvalid, core_reset;
  wire         bus_master, power, refresh, fetch;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [63:0] fetch_vector;
  rsev_cause_e cause;
  logic [33:0] q[$]; // expected {rresp, rdata}
  logic [31:0] off[5] = '{32'h0, 32'h100, 32'h0, 32'h80, 32'h180};
  int          failures = 0, samples_checked = 0, n;
  // short timer limits keep the run brief
  rsev_top #(.HALT_CYC(300), .DEAD_CYC(100)) dut_u (.i_clk(i_clk),
    .i_rst(i_rst), .i_rtc_domain_reset_pin(rtc_pin),
    .i_reset_switch_pin(sw_pin), .i_awvalid(awvalid), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .i_wdata(wdata), .i_wstrb(wstrb), .i_bready(bready),
    .i_arvalid(arvalid), .i_araddr(araddr), .i_rready(rready),
    .o_awready(awready), .o_wready(wready), .o_bvalid(bvalid),
    .o_bresp(bresp), .o_arready(arready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_rresp(rresp), .o_core_reset(core_reset),
    .o_bus_master(bus_master), .o_fetch_strobe(fetch),
    .o_fetch_vector(fetch_vector), .o_main_power_output(power),
    .o_dram_self_refresh(refresh), .o_reset_cause(cause));
  rsev_power_model pm_u (.i_clk(i_clk), .i_press(press),
    .o_rtc_domain_reset_pin(rtc_pin), .o_reset_switch_pin(sw_pin));
  // 20 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task end_sim;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // write: address and data offered together, each dropped when taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= d;
    do
    begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    chk("bresp", bresp, 2'h0);
    bready <= 1'b0;
  endtask : wr
  // read: the expectation is queued, the monitor compares it
  task automatic rd(logic [7:0] a, logic [33:0] e);
    q.push_back(e);
    @(posedge i_clk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do
    begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // core held in reset with the given cause
  task automatic wait_cause(rsev_cause_e c, int lim);
    for (n = 0; n < lim && !(cause === c && core_reset === 1'b1); n++)
      @(posedge i_clk);
    chk("cause", cause, c);
    chk("core_reset", core_reset, 1'b1);
  endtask : wait_cause
  // core released, bus owned, fetch aimed at the reset vector
  task automatic wait_run;
    for (n = 0; n < 100 && fetch !== 1'b1; n++)
      @(posedge i_clk);
    chk("fetch_strobe", fetch, 1'b1);
    chk("fetch", fetch_vector, 64'h0000_0000_bfc0_0000);
    @(posedge i_clk);
    chk("bus_master", bus_master, 1'b1);
    chk("core_reset", core_reset, 1'b0);
  endtask : wait_run
  always @(posedge i_clk)
    if (rvalid && rready)
      chk("read", {rresp, rdata}, q.pop_front());
  // watchdog: the tests need about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    failures++;
    end_sim();
  end
  initial
  begin
    {press, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    i_rst = 1'b1;
    n = $urandom(37421);
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    wait_run();
    wait_cause(rsev_cause_halt, 400);
    wait_run();
    rd(8'h00, 34'h0_0040_0004);
    rd(8'h08, 34'h0);
    rd(8'h0c, 34'h0_0002_4000);
    rd(8'h3c, 34'h2_0000_0000);
    $display("test halt and reset values done");
    for (int m = 0; m < 2; m++)
      for (int b = 0; b < 2; b++)
        for (int c = 0; c < 5; c++)
        begin
          wr(8'h00, (b == 1) ? 32'h0040_0000 : 32'h0);
          wr(8'h10, (m == 1) ? 32'h14 : 32'h04);
          wr(8'h14, (c < 4) ? c : 4 + $urandom % 4);
          rd(8'h18, {2'h0, ((c == 0) ? 32'hbfc0_0000 : (b == 1) ?
            32'hbfc0_0200 : (c == 1) ? 32'ha000_0000 : 32'h8000_0000)
            + off[c]});
          rd(8'h1c, (m == 1) ? 34'h0_ffff_ffff : 34'h0);
        end
    $display("test vectors done");
    wr(8'h10, 32'h1);
    wait_cause(rsev_cause_deadman, 300);
    chk("refresh", refresh, 1'b0);
    wait_run();
    wr(8'h10, 32'h8);
    wait_cause(rsev_cause_shutdown, 50);
    chk("power", power, 1'b0);
    chk("refresh", refresh, 1'b1);
    press <= 1'b1;
    repeat (4) @(posedge i_clk);
    press <= 1'b0;
    wait_cause(rsev_cause_switch, 50);
    wait_run();
    chk("power", power, 1'b1);
    rd(8'h00, 34'h0_0040_0004);
    $display("test watchdog shutdown switch done");
    end_sim();
  end
endmodule : reset_sources_and_exception_vectors_test
